// ==== crossover_scan.sv ====
// Automatic straight/cross hunting while no link is present
`timescale 1ns/1ns
`include "ext_ctl_cfg.svh"
module crossover_scan
#(
  parameter int SCAN_CYCLES = `SCAN_CYCLES
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Control
  input wire logic run,
  input wire logic link_seen,
  // Selection
  output ext_ctl_pkg::pair_assign_t pick
);
  ext_ctl_pkg::pair_assign_t pick_q, pick_d;
  logic [31:0] cnt_q, cnt_d;

  always_comb
  begin
    pick_d = pick_q;
    cnt_d = 32'h0000_0000;
    // Alternate until link activity shows up
    if (run && !link_seen)
    begin
      cnt_d = cnt_q + 32'h0000_0001;
      if (cnt_q >= 32'(SCAN_CYCLES - 1))
      begin
        cnt_d = 32'h0000_0000;
        pick_d = (pick_q == ext_ctl_pkg::PAIR_STRAIGHT) ?
          ext_ctl_pkg::PAIR_CROSS : ext_ctl_pkg::PAIR_STRAIGHT;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pick_q <= ext_ctl_pkg::PAIR_STRAIGHT;
      cnt_q <= 32'h0000_0000;
    end
    else
    begin
      pick_q <= pick_d;
      cnt_q <= cnt_d;
    end
  end

  assign pick = pick_q;
endmodule

// ==== ext_ctl_cfg.svh ====
// Constants for the extended control register two block
`ifndef EXT_CTL_CFG_SVH
`define EXT_CTL_CFG_SVH
`define REG_ADDR_EXT_CTL2 5'h13
`define BIT_NODE_CFG 15
`define BIT_SW_CFG 14
`define BIT_REMOTE_FAULT 13
`define BIT_RSVD_RO 10
`define BIT_AUTO_XOVER 9
`define BIT_FORCE_SEL 8
`define BIT_TRISTATE 7
`define BIT_AUTO_PD 0
`define EXT_CTL2_RESET 16'h4201
`define EXT_CTL2_RW_MASK 16'h1BFF
`define SCAN_TIME_NS 32'd1000000
`define CLK_PERIOD_NS 32'd8
`define SCAN_CYCLES (`SCAN_TIME_NS / `CLK_PERIOD_NS)
`endif

// ==== ext_ctl_pkg.sv ====
// Types for the extended control register two block
package ext_ctl_pkg;
  typedef enum logic
  {
    PAIR_STRAIGHT,
    PAIR_CROSS
  } pair_assign_t;

  typedef struct packed
  {
    logic auto_crossover_enable;
    logic crossover_force_select;
    logic pair_output_tristate;
    logic auto_power_down;
  } ctl_bits_t;

  typedef struct packed
  {
    logic tx_on_b;
    logic tristate;
    logic tx100_power_off;
  } line_ctl_t;
endpackage

// ==== mdio_slave.sv ====
// Management frame engine for a single register address
`timescale 1ns/1ns
`include "ext_ctl_cfg.svh"
module mdio_slave
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Management pins
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic [4:0] phy_addr,
  // Register port
  input wire logic [15:0] rd_data,
  output logic wr_en,
  output logic [15:0] wr_data
);
  typedef enum logic [2:0]
  {
    S_PRE,
    S_HDR,
    S_TA,
    S_READ,
    S_WRITE
  } mstate_t;

  mstate_t st_q, st_d;
  logic mdc_q, mdc_d;
  logic [5:0] cnt_q, cnt_d;
  logic [13:0] hdr_q, hdr_d;
  logic [15:0] sh_q, sh_d;
  logic hit_q, hit_d;
  logic out_q, out_d, oe_q, oe_d, we_q, we_d;

  // Rising edge of mdc samples, falling edge drives
  logic rise, fall;
  assign rise = mdc & ~mdc_q;
  assign fall = ~mdc & mdc_q;

  always_comb
  begin
    st_d = st_q;
    mdc_d = mdc;
    cnt_d = cnt_q;
    hdr_d = hdr_q;
    sh_d = sh_q;
    hit_d = hit_q;
    out_d = out_q;
    oe_d = oe_q;
    we_d = 1'b0;
    case (st_q)
      S_PRE:
      begin
        if (rise)
        begin
          cnt_d = mdio_in ? 6'(cnt_q + 6'h01) : 6'h00;
          if (!mdio_in && cnt_q >= 6'h20)
          begin
            st_d = S_HDR;
            cnt_d = 6'h00;
          end
        end
      end
      S_HDR:
      begin
        if (rise)
        begin
          hdr_d = {hdr_q[12:0], mdio_in};
          cnt_d = 6'(cnt_q + 6'h01);
          if (cnt_q == 6'h0C)
          begin
            // Header is ST1, OP, PHYAD, REGAD
            // Opcode bits masked out, checked later per state
            hit_d = ({hdr_q[11:0], mdio_in} & 13'h13FF) ==
              {1'b1, 2'b00, phy_addr, `REG_ADDR_EXT_CTL2};
            st_d = S_TA;
            cnt_d = 6'h00;
            sh_d = rd_data;
          end
        end
      end
      S_TA:
      begin
        if (rise)
        begin
          cnt_d = 6'(cnt_q + 6'h01);
          if (cnt_q == 6'h01)
          begin
            cnt_d = 6'h00;
            st_d = (hdr_q[11:10] == 2'b10) ? S_READ : S_WRITE;
          end
        end
        if (fall && cnt_q == 6'h01 && hit_q && hdr_q[11:10] == 2'b10)
        begin
          oe_d = 1'b1;
          out_d = 1'b0;
        end
      end
      S_READ:
      begin
        if (fall)
        begin
          out_d = sh_q[15];
          sh_d = {sh_q[14:0], 1'b0};
        end
        if (rise)
        begin
          cnt_d = 6'(cnt_q + 6'h01);
          if (cnt_q == 6'h0F)
          begin
            st_d = S_PRE;
            cnt_d = 6'h00;
          end
        end
        if (fall && cnt_q == 6'h10)
          oe_d = 1'b0;
      end
      S_WRITE:
      begin
        if (rise)
        begin
          sh_d = {sh_q[14:0], mdio_in};
          cnt_d = 6'(cnt_q + 6'h01);
          if (cnt_q == 6'h0F)
          begin
            we_d = hit_q && hdr_q[11:10] == 2'b01;
            st_d = S_PRE;
            cnt_d = 6'h00;
          end
        end
      end
      default: st_d = S_PRE;
    endcase
    if (st_q == S_PRE && fall)
      oe_d = 1'b0;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q <= S_PRE;
      mdc_q <= 1'b0;
      cnt_q <= 6'h00;
      hdr_q <= 14'h0000;
      sh_q <= 16'h0000;
      hit_q <= 1'b0;
      out_q <= 1'b0;
      oe_q <= 1'b0;
      we_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      mdc_q <= mdc_d;
      cnt_q <= cnt_d;
      hdr_q <= hdr_d;
      sh_q <= sh_d;
      hit_q <= hit_d;
      out_q <= out_d;
      oe_q <= oe_d;
      we_q <= we_d;
    end
  end

  assign mdio_out = out_q;
  assign mdio_oe = oe_q;
  assign wr_en = we_q;
  assign wr_data = sh_q;
endmodule

// ==== mgmt_station.sv ====
// Station management model driving frames over a pulled-up data line
`timescale 1ns/1ns
module mgmt_station
(
  // Clock
  input wire logic clk,
  // Device side of the data line
  input wire logic mdio_out,
  input wire logic mdio_oe,
  // Management pins
  output logic mdc,
  output logic mdio_in
);
  logic drv = 1'b0;
  logic dat = 1'b1;
  int half_clks = 5;
  initial mdc = 1'b0;
  // Released line floats to the pull-up level
  assign mdio_in = mdio_oe ? mdio_out : (drv ? dat : 1'b1);

  task automatic half();
    repeat (half_clks) @(posedge clk);
    #1;
  endtask

  // One bit: drive while low, sample at the rise
  task automatic cyc(input logic d, input logic b, output logic s);
    drv = d;
    dat = b;
    half();
    mdc = 1'b1;
    s = mdio_in;
    half();
    mdc = 1'b0;
  endtask

  task automatic frame(input logic wr, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [13:0] hdr;
    logic s;
    hdr = {2'b01, (wr ? 2'b01 : 2'b10), pa, ra};
    for (int i = 0; i < 32; i++)
      cyc(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--)
      cyc(1'b1, hdr[i], s);
    cyc(wr, 1'b1, s);
    cyc(wr, 1'b0, s);
    for (int i = 15; i >= 0; i--)
    begin
      cyc(wr, wd[i], s);
      rd[i] = s;
    end
    drv = 1'b0;
  endtask
endmodule

// ==== phy_ext_control_crossover.sv ====
// Extended control register two with crossover and power controls
// Notes on behaviour
// - Bit 15 reads 0: node
// - Node: carrier on any activity, SQE on
// - Bit 14 reads 1: software configuration
// - Bit 13 mirrors partner remote fault
// - Bits 9,8 writable, reset 1 and 0
// - Enable bit low: force bit picks pairs
// - Enable bit high, pin low: straight
// - Pin and bit high: auto select
// - Straight tx A rx B; cross reversed
// - Bit 7 tristates transmit outputs
// - Bit 0 powers off 100TX in 10M
// - Isolate also powers off 100TX
// - Reserved bits writable except bit 10
// - Auto crossover may stall on inverted polarity
`timescale 1ns/1ns
`include "ext_ctl_cfg.svh"
module phy_ext_control_crossover
#(
  parameter int SCAN_CYCLES = `SCAN_CYCLES
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Management interface
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic [4:0] phy_addr,
  // Core status
  input wire logic auto_crossover_enable_pin,
  input wire logic partner_remote_fault,
  input wire logic link_activity,
  input wire logic mode_10m,
  input wire logic isolate,
  input wire logic tx_activity,
  input wire logic rx_activity,
  // Line control
  output logic carrier_sense,
  output logic sqe_test_enable,
  output ext_ctl_pkg::line_ctl_t line_ctl,
  output ext_ctl_pkg::ctl_bits_t ctl_bits
);
  logic [15:0] reg_q, reg_d;
  logic rf_q, rf_d;
  logic crs_q, crs_d;
  ext_ctl_pkg::line_ctl_t line_q, line_d;
  logic wr_en;
  logic [15:0] wr_data, rd_data;
  ext_ctl_pkg::pair_assign_t scan_pick, sel;
  logic auto_run;

  // ----------------------------------------
  // Management access
  // ----------------------------------------
  mdio_slave u_mdio
  (
    .clk(clk),
    .rstn(rstn),
    .mdc(mdc),
    .mdio_in(mdio_in),
    .mdio_out(mdio_out),
    .mdio_oe(mdio_oe),
    .phy_addr(phy_addr),
    .rd_data(rd_data),
    .wr_en(wr_en),
    .wr_data(wr_data)
  );

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  always_comb
  begin
    reg_d = reg_q;
    if (wr_en)
      reg_d = (wr_data & `EXT_CTL2_RW_MASK) | (reg_q & ~`EXT_CTL2_RW_MASK);
    reg_d[`BIT_NODE_CFG] = 1'b0;
    reg_d[`BIT_SW_CFG] = 1'b1;
    reg_d[`BIT_RSVD_RO] = 1'b0;
    rf_d = partner_remote_fault;
    crs_d = tx_activity | rx_activity;
  end

  always_comb
  begin
    rd_data = reg_q;
    rd_data[`BIT_REMOTE_FAULT] = rf_q;
  end

  // ----------------------------------------
  // Crossover selection
  // ----------------------------------------
  // Scan ignores polarity; clearing bit 9 lets software stop it
  assign auto_run = reg_q[`BIT_AUTO_XOVER] & auto_crossover_enable_pin;

  crossover_scan #(.SCAN_CYCLES(SCAN_CYCLES)) u_scan
  (
    .clk(clk),
    .rstn(rstn),
    .run(auto_run),
    .link_seen(link_activity),
    .pick(scan_pick)
  );

  always_comb
  begin
    if (!reg_q[`BIT_AUTO_XOVER])
      sel = reg_q[`BIT_FORCE_SEL] ? ext_ctl_pkg::PAIR_CROSS
        : ext_ctl_pkg::PAIR_STRAIGHT;
    else if (!auto_crossover_enable_pin)
      sel = ext_ctl_pkg::PAIR_STRAIGHT;
    else
      sel = scan_pick;
    line_d.tx_on_b = (sel == ext_ctl_pkg::PAIR_CROSS);
    line_d.tristate = reg_q[`BIT_TRISTATE];
    line_d.tx100_power_off = (reg_q[`BIT_AUTO_PD] & mode_10m) | isolate;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      reg_q <= `EXT_CTL2_RESET;
      rf_q <= 1'b0;
      crs_q <= 1'b0;
      line_q <= '0;
    end
    else
    begin
      reg_q <= reg_d;
      rf_q <= rf_d;
      crs_q <= crs_d;
      line_q <= line_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign carrier_sense = crs_q;
  assign sqe_test_enable = 1'b1;
  assign line_ctl = line_q;
  assign ctl_bits = '{reg_q[`BIT_AUTO_XOVER], reg_q[`BIT_FORCE_SEL],
    reg_q[`BIT_TRISTATE], reg_q[`BIT_AUTO_PD]};

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_node_bit_zero: assert property (@(posedge clk) disable iff (!rstn)
    !rd_data[`BIT_NODE_CFG]) else $error("node bit not zero");
  a_sw_bit_one: assert property (@(posedge clk) disable iff (!rstn)
    rd_data[`BIT_SW_CFG]) else $error("software bit not one");
  a_fault_mirror: assert property (@(posedge clk) disable iff (!rstn)
    ##1 rd_data[`BIT_REMOTE_FAULT] == $past(partner_remote_fault))
    else $error("remote fault not mirrored");
  a_force_select: assert property (@(posedge clk) disable iff (!rstn)
    !reg_q[`BIT_AUTO_XOVER] |=> line_ctl.tx_on_b == $past(reg_q[`BIT_FORCE_SEL]))
    else $error("force select ignored");
  a_pin_straight: assert property (@(posedge clk) disable iff (!rstn)
    reg_q[`BIT_AUTO_XOVER] && !auto_crossover_enable_pin |=> !line_ctl.tx_on_b)
    else $error("pin low not straight");
  a_tristate_follow: assert property (@(posedge clk) disable iff (!rstn)
    ##1 line_ctl.tristate == $past(reg_q[`BIT_TRISTATE]))
    else $error("tristate mismatch");
  a_auto_pd: assert property (@(posedge clk) disable iff (!rstn)
    ##1 line_ctl.tx100_power_off ==
      $past((reg_q[`BIT_AUTO_PD] & mode_10m) | isolate))
    else $error("power down mismatch");
  a_ro_reserved: assert property (@(posedge clk) disable iff (!rstn)
    wr_en |=> !reg_q[`BIT_RSVD_RO]) else $error("reserved bit written");
  a_crs_follow: assert property (@(posedge clk) disable iff (!rstn)
    (tx_activity || rx_activity) |=> carrier_sense) else $error("carrier missed");

  // ----------------------------------------
  // Further checks
  // ----------------------------------------
  // Read turnaround starts with a driven zero
  sequence s_drive_start;
    $rose(mdio_oe);
  endsequence

  // Auto mode parked on a live link
  sequence s_link_hold;
    auto_run && link_activity;
  endsequence

  a_crs_drop: assert property (@(posedge clk) disable iff (!rstn)
    !(tx_activity || rx_activity) |=> !carrier_sense)
    else $error("carrier held without activity");

  a_sqe_on: assert property (@(posedge clk) disable iff (!rstn)
    sqe_test_enable)
    else $error("signal quality test off");

  a_ro_top_bits: assert property (@(posedge clk) disable iff (!rstn)
    !reg_q[`BIT_NODE_CFG] && reg_q[`BIT_SW_CFG])
    else $error("read-only mode bits changed");

  a_rsvd_ro_zero: assert property (@(posedge clk) disable iff (!rstn)
    !rd_data[`BIT_RSVD_RO])
    else $error("read-only reserved bit set");

  a_write_lands: assert property (@(posedge clk) disable iff (!rstn)
    wr_en |=> (reg_q & `EXT_CTL2_RW_MASK) ==
      ($past(wr_data) & `EXT_CTL2_RW_MASK))
    else $error("write not stored");

  a_hold_no_write: assert property (@(posedge clk) disable iff (!rstn)
    !wr_en |=> reg_q == $past(reg_q))
    else $error("register changed without write");

  a_ctl_mirror: assert property (@(posedge clk) disable iff (!rstn)
    ctl_bits == {reg_q[`BIT_AUTO_XOVER], reg_q[`BIT_FORCE_SEL],
      reg_q[`BIT_TRISTATE], reg_q[`BIT_AUTO_PD]})
    else $error("control bits not mirrored");

  a_auto_follow: assert property (@(posedge clk) disable iff (!rstn)
    auto_run |=> line_ctl.tx_on_b == $past(scan_pick == ext_ctl_pkg::PAIR_CROSS))
    else $error("auto pick not applied");

  a_scan_hold: assert property (@(posedge clk) disable iff (!rstn)
    s_link_hold |=> scan_pick == $past(scan_pick))
    else $error("scan moved with link up");

  a_iso_power: assert property (@(posedge clk) disable iff (!rstn)
    isolate |=> line_ctl.tx100_power_off)
    else $error("isolate kept 100TX on");

  a_no_auto_pd: assert property (@(posedge clk) disable iff (!rstn)
    !reg_q[`BIT_AUTO_PD] && !isolate |=> !line_ctl.tx100_power_off)
    else $error("100TX off without cause");

  a_turn_zero: assert property (@(posedge clk) disable iff (!rstn)
    s_drive_start |-> !mdio_out)
    else $error("turnaround bit not zero");
endmodule

// ==== tb_phy_ext_control_crossover.sv ====
// Self-checking bench for extended control register two
`timescale 1ns/1ns
module tb_phy_ext_control_crossover;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic mdc, mdio_in, mdio_out, mdio_oe, crs, sqe;
  logic pin = 1'b1, rf = 1'b0, link = 1'b1, m10 = 1'b0, iso = 1'b0, txa = 1'b0, rxa = 1'b0;
  logic [4:0] pa = 5'h05;
  ext_ctl_pkg::line_ctl_t line_ctl;
  ext_ctl_pkg::ctl_bits_t ctl_bits;
  int miscompares = 0;
  int n_tests = 0;
  logic [15:0] exp_q[$];
  logic [15:0] seen_q[$];

  always #4 clk = ~clk;

  phy_ext_control_crossover #(.SCAN_CYCLES(8)) phy_ext_control_crossover_i
  (
    .clk(clk), .rstn(rstn), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .phy_addr(pa), .auto_crossover_enable_pin(pin),
    .partner_remote_fault(rf), .link_activity(link), .mode_10m(m10), .isolate(iso),
    .tx_activity(txa), .rx_activity(rxa), .carrier_sense(crs), .sqe_test_enable(sqe),
    .line_ctl(line_ctl), .ctl_bits(ctl_bits)
  );

  mgmt_station mgmt_station_i
  (
    .clk(clk), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .mdc(mdc), .mdio_in(mdio_in)
  );

  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask

  task automatic note(input logic [15:0] got, input logic [15:0] exp);
    exp_q.push_back(exp);
    seen_q.push_back(got);
  endtask

  always @(posedge clk)
  begin
    while (seen_q.size() > 0)
      check(seen_q.pop_front(), exp_q.pop_front());
  end

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic rd(input logic [4:0] a, input logic [4:0] ra, input logic [15:0] exp);
    logic [15:0] v;
    mgmt_station_i.frame(1'b0, a, ra, 16'h0000, v);
    note(v, exp);
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] v;
    mgmt_station_i.frame(1'b1, a, 5'h13, d, v);
  endtask

  // Status outputs against a settled expectation
  task automatic pins(input logic [15:0] w, input logic tx);
    logic pd;
    repeat (3) @(posedge clk);
    #1;
    pd = (w[0] & m10) | iso;
    note({7'h00, crs, sqe, ctl_bits, line_ctl},
         {7'h00, txa | rxa, 1'b1, w[9], w[8], w[7], w[0], tx, w[7], pd});
  endtask

  // Toggles of the pair choice over 40 cycles
  task automatic toggles(output int n);
    logic last;
    n = 0;
    last = line_ctl.tx_on_b;
    repeat (40)
    begin
      @(posedge clk);
      #1;
      if (line_ctl.tx_on_b !== last)
        n++;
      last = line_ctl.tx_on_b;
    end
  endtask

  initial
  begin
    repeat (100000) @(posedge clk);
    miscompares++;
    finish_test();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    logic [15:0] w;
    logic tx;
    int n;
    n = $urandom(83);
    repeat (20) @(posedge clk);
    #1;
    rstn = 1'b1;
    pins(16'h4201, 1'b0);
    rd(pa, 5'h13, 16'h4201);
    for (int k = 0; k < 16; k++)
    begin
      w = 16'($urandom()) & 16'he181;
      w[9] = k[0];
      w[8] = k[1];
      pin = k[2];
      {rf, m10, iso, txa, rxa} = 5'($urandom());
      wr(pa, w);
      tx = w[9] ? 1'b0 : w[8];
      pins(w, tx);
      rd(pa, 5'h13, 16'h4000 | (16'(rf) << 13) | (w & 16'h0381));
    end
    mgmt_station_i.half_clks = 12;
    rd(pa, 5'h12, 16'hffff);
    mgmt_station_i.half_clks = 5;
    wr(pa ^ 5'h01, 16'h0080);
    rd(pa ^ 5'h01, 5'h13, 16'hffff);
    rd(pa, 5'h13, 16'h4000 | (16'(rf) << 13) | (w & 16'h0381));
    pin = 1'b1;
    wr(pa, 16'h0200);
    link = 1'b0;
    toggles(n);
    note({15'h0000, n >= 4 && n <= 6}, 16'h0001);
    link = 1'b1;
    repeat (3) @(posedge clk);
    toggles(n);
    note(16'(n), 16'h0000);
    pin = 1'b0;
    pins(16'h0200, 1'b0);
    repeat (4) @(posedge clk);
    finish_test();
  end
endmodule
